// ---- rtl/scm_pkg.sv ----
// What this block does
// - The row strobe is driven low only while a valid row address stands on the address pins.
// - The column strobe is driven low only while a valid column address stands on the address pins.
// - The write strobe is low for write commands and high for read commands.
// - Two block selects each pick one memory block and are never used as a row strobe.
// - The clock enable is driven by the block, and low lets the memory power down or self-refresh.
// - With the command select bit set, the clock enable carries a command bit instead.
// - The two byte mask outputs serve as per-byte data masks for the memory.
// - The block drives the memory clock, and every command and address output is timed to it.
// - In the row phase address pins 9 to 25 carry the address bit of the same index.
// - In the column phase pins 15..9 carry bits 2..8, pin 16 bit 1 for 8/16-bit ports, pin 17 bit 0 for 8-bit.
// - On a 32-bit port pin 17 carries bit 16, and pin 18 carries bit 17 for 16-bit or 32-bit with 8 columns.
// - Pins 19..25 carry bits 18..24, except pin 19 on a 16-bit port with fewer than nine columns.
//
// Purpose: Constants and types of the memory command and address multiplexer
// Assumes: Port width and column count are fixed per request by the caller
// Notes:   Commands are packed as row strobe, column strobe, write strobe
package scm_pkg;
    localparam int unsigned ADDR_W      = 32;
    localparam int unsigned PIN_LO      = 9;
    localparam int unsigned PIN_HI      = 25;
    localparam int unsigned PIN_W       = PIN_HI - PIN_LO + 1;
    localparam int unsigned COL_LO_TOP  = 17;
    localparam logic [1:0]  PORT_32     = 2'h0;
    localparam logic [1:0]  PORT_8      = 2'h1;
    localparam logic [1:0]  PORT_16     = 2'h2;
    localparam logic [3:0]  COLS_8      = 4'h8;
    localparam logic [3:0]  COLS_9      = 4'h9;
    localparam int unsigned ACT_TO_CMD  = 2;
    localparam logic [2:0]  CMD_NOP     = 3'h7;
    localparam logic [2:0]  CMD_ACT     = 3'h3;
    localparam logic [2:0]  CMD_READ    = 3'h5;
    localparam logic [2:0]  CMD_WRITE   = 3'h4;
    localparam logic [1:0]  SEL_NONE    = 2'h3;
    localparam logic [1:0]  MASK_RESET  = 2'h3;
    localparam logic        CKE_RESET   = 1'h0;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_CMD  = 3'h4
    } scm_state_e;
endpackage

// ---- rtl/scm_sdram_cmd_mux.sv ----
// Purpose: Memory command strobes and row/column address multiplexing
// Assumes: Requests come from logic on clk, memory side runs on link_clk
// Notes:   Memory clock is link_clk divided by two, outputs change as it falls
`timescale 1ns/10ps
module scm_sdram_cmd_mux #(
    parameter int unsigned ACT_GAP = scm_pkg::ACT_TO_CMD
) (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      link_clk,
    input  wire logic                      req_valid,
    input  wire logic                      req_write,
    input  wire logic [scm_pkg::ADDR_W-1:0] req_addr,
    input  wire logic                      req_block,
    input  wire logic [1:0]                req_byte_mask,
    input  wire logic [1:0]                port_size,
    input  wire logic [3:0]                col_lines,
    input  wire logic                      power_down,
    input  wire logic                      cke_command_select,
    input  wire logic                      cke_command_bit,
    output logic                           req_ready,
    output logic                           req_done,
    output logic                           mem_clock_out,
    output logic                           row_strobe_n,
    output logic                           column_strobe_n,
    output logic                           mem_write_strobe_n,
    output logic [1:0]                     mem_block_select_n,
    output logic                           mem_clock_enable,
    output logic [1:0]                     byte_mask_out,
    output logic [scm_pkg::PIN_HI:scm_pkg::PIN_LO] mem_addr_out
);
    // Request side, clk domain
    logic                       ready_reg, ready_next;
    logic                       done_reg, done_next;
    logic                       req_tgl_reg, req_tgl_next;
    logic [scm_pkg::ADDR_W-1:0] hold_addr_reg, hold_addr_next;
    logic                       hold_write_reg, hold_write_next;
    logic                       hold_block_reg, hold_block_next;
    logic [1:0]                 hold_mask_reg, hold_mask_next;
    logic [1:0]                 hold_port_reg, hold_port_next;
    logic [3:0]                 hold_cols_reg, hold_cols_next;
    logic                       ack_s1_reg, ack_s2_reg, ack_seen_reg, ack_seen_next;
    // Memory side, link_clk domain
    logic                       lrst_s1_reg, lrst_s2_reg;
    logic                       link_rst_n;
    logic                       req_s1_reg, req_s2_reg;
    logic                       pd_s1_reg, pd_s2_reg;
    logic                       csel_s1_reg, csel_s2_reg;
    logic                       cbit_s1_reg, cbit_s2_reg;
    scm_pkg::scm_state_e        state_reg, state_next;
    logic                       mclk_reg, mclk_next;
    logic [7:0]                 cnt_reg, cnt_next;
    logic [2:0]                 cmd_reg, cmd_next;
    logic [1:0]                 sel_reg, sel_next;
    logic [1:0]                 mask_reg, mask_next;
    logic                       cke_reg, cke_next;
    logic [scm_pkg::PIN_HI:scm_pkg::PIN_LO] addr_reg, addr_next;
    logic                       req_seen_reg, req_seen_next;
    logic                       ack_tgl_reg, ack_tgl_next;
    logic [scm_pkg::PIN_HI:scm_pkg::PIN_LO] row_addr, col_addr;
    logic                       is_8, is_16, is_32, pending, cke_ok;

    assign req_ready          = ready_reg;
    assign req_done           = done_reg;
    assign mem_clock_out      = mclk_reg;
    assign row_strobe_n       = cmd_reg[2];
    assign column_strobe_n    = cmd_reg[1];
    assign mem_write_strobe_n = cmd_reg[0];
    assign mem_block_select_n = sel_reg;
    assign mem_clock_enable   = cke_reg;
    assign byte_mask_out      = mask_reg;
    assign mem_addr_out       = addr_reg;
    assign link_rst_n         = lrst_s2_reg;

    // Hold registers stay still until the ack returns, so the link side may read them
    always_comb begin
        ready_next      = ready_reg;
        done_next       = 1'b0;
        req_tgl_next    = req_tgl_reg;
        hold_addr_next  = hold_addr_reg;
        hold_write_next = hold_write_reg;
        hold_block_next = hold_block_reg;
        hold_mask_next  = hold_mask_reg;
        hold_port_next  = hold_port_reg;
        hold_cols_next  = hold_cols_reg;
        ack_seen_next   = ack_seen_reg;
        if (ack_s2_reg != ack_seen_reg) begin
            ack_seen_next = ack_s2_reg;
            ready_next    = 1'b1;
            done_next     = 1'b1;
        end else if (req_valid && ready_reg) begin
            ready_next      = 1'b0;
            req_tgl_next    = ~req_tgl_reg;
            hold_addr_next  = req_addr;
            hold_write_next = req_write;
            hold_block_next = req_block;
            hold_mask_next  = req_byte_mask;
            hold_port_next  = port_size;
            hold_cols_next  = col_lines;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_reg      <= 1'b1;
            done_reg       <= 1'b0;
            req_tgl_reg    <= 1'b0;
            hold_addr_reg  <= '0;
            hold_write_reg <= 1'b0;
            hold_block_reg <= 1'b0;
            hold_mask_reg  <= 2'h0;
            hold_port_reg  <= scm_pkg::PORT_32;
            hold_cols_reg  <= scm_pkg::COLS_8;
            ack_s1_reg     <= 1'b0;
            ack_s2_reg     <= 1'b0;
            ack_seen_reg   <= 1'b0;
        end else begin
            ready_reg      <= ready_next;
            done_reg       <= done_next;
            req_tgl_reg    <= req_tgl_next;
            hold_addr_reg  <= hold_addr_next;
            hold_write_reg <= hold_write_next;
            hold_block_reg <= hold_block_next;
            hold_mask_reg  <= hold_mask_next;
            hold_port_reg  <= hold_port_next;
            hold_cols_reg  <= hold_cols_next;
            ack_s1_reg     <= ack_tgl_reg;
            ack_s2_reg     <= ack_s1_reg;
            ack_seen_reg   <= ack_seen_next;
        end
    end

    // Reset for the link side, asserted at once and released on link_clk
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_s1_reg <= 1'b0;
            lrst_s2_reg <= 1'b0;
        end else begin
            lrst_s1_reg <= 1'b1;
            lrst_s2_reg <= lrst_s1_reg;
        end
    end

    // Row and column pin maps
    always_comb begin
        is_8     = (hold_port_reg == scm_pkg::PORT_8);
        is_16    = (hold_port_reg == scm_pkg::PORT_16);
        is_32    = !is_8 && !is_16;
        row_addr = hold_addr_reg[scm_pkg::PIN_HI:scm_pkg::PIN_LO];
        col_addr = '0;
        for (int p = scm_pkg::PIN_LO; p <= 15; p++) begin
            col_addr[p] = hold_addr_reg[scm_pkg::COL_LO_TOP - p];
        end
        if (!is_32) begin
            col_addr[16] = hold_addr_reg[1];
        end
        if (is_8) begin
            col_addr[17] = hold_addr_reg[0];
        end else if (is_32) begin
            col_addr[17] = hold_addr_reg[16];
        end
        if (is_16 || (is_32 && hold_cols_reg == scm_pkg::COLS_8)) begin
            col_addr[18] = hold_addr_reg[17];
        end
        if (!(is_16 && hold_cols_reg < scm_pkg::COLS_9)) begin
            col_addr[19] = hold_addr_reg[18];
        end
        for (int p = 20; p <= scm_pkg::PIN_HI; p++) begin
            col_addr[p] = hold_addr_reg[p - 1];
        end
    end

    // Commands change only as the memory clock falls, so they are settled at its rise
    always_comb begin
        pending        = (req_s2_reg != req_seen_reg);
        cke_ok         = csel_s2_reg || !pd_s2_reg;
        mclk_next      = ~mclk_reg;
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        cmd_next       = cmd_reg;
        sel_next       = sel_reg;
        mask_next      = mask_reg;
        cke_next       = cke_reg;
        addr_next      = addr_reg;
        req_seen_next  = req_seen_reg;
        ack_tgl_next   = ack_tgl_reg;
        if (mclk_reg) begin
            cmd_next = scm_pkg::CMD_NOP;
            sel_next = scm_pkg::SEL_NONE;
            cke_next = csel_s2_reg ? cbit_s2_reg : !pd_s2_reg;
            case (state_reg)
                scm_pkg::ST_IDLE: begin
                    // No activation while power_down is set, unless cke_command_select is set
                    if (pending && cke_ok) begin
                        cmd_next   = scm_pkg::CMD_ACT;
                        addr_next  = row_addr;
                        sel_next   = hold_block_reg ? 2'h1 : 2'h2;
                        cnt_next   = 8'(ACT_GAP - 1);
                        state_next = scm_pkg::ST_WAIT;
                    end
                end
                scm_pkg::ST_WAIT: begin
                    if (cnt_reg == 8'h00) begin
                        cmd_next   = hold_write_reg ? scm_pkg::CMD_WRITE : scm_pkg::CMD_READ;
                        addr_next  = col_addr;
                        sel_next   = hold_block_reg ? 2'h1 : 2'h2;
                        mask_next  = hold_mask_reg;
                        state_next = scm_pkg::ST_CMD;
                    end else begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                end
                scm_pkg::ST_CMD: begin
                    mask_next     = scm_pkg::MASK_RESET;
                    req_seen_next = req_s2_reg;
                    ack_tgl_next  = ~ack_tgl_reg;
                    state_next    = scm_pkg::ST_IDLE;
                end
                default: begin
                    state_next = scm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            req_s1_reg   <= 1'b0;
            req_s2_reg   <= 1'b0;
            pd_s1_reg    <= 1'b0;
            pd_s2_reg    <= 1'b0;
            csel_s1_reg  <= 1'b0;
            csel_s2_reg  <= 1'b0;
            cbit_s1_reg  <= 1'b0;
            cbit_s2_reg  <= 1'b0;
            state_reg    <= scm_pkg::ST_IDLE;
            mclk_reg     <= 1'b0;
            cnt_reg      <= 8'h00;
            cmd_reg      <= scm_pkg::CMD_NOP;
            sel_reg      <= scm_pkg::SEL_NONE;
            mask_reg     <= scm_pkg::MASK_RESET;
            cke_reg      <= scm_pkg::CKE_RESET;
            addr_reg     <= '0;
            req_seen_reg <= 1'b0;
            ack_tgl_reg  <= 1'b0;
        end else begin
            req_s1_reg   <= req_tgl_reg;
            req_s2_reg   <= req_s1_reg;
            pd_s1_reg    <= power_down;
            pd_s2_reg    <= pd_s1_reg;
            csel_s1_reg  <= cke_command_select;
            csel_s2_reg  <= csel_s1_reg;
            cbit_s1_reg  <= cke_command_bit;
            cbit_s2_reg  <= cbit_s1_reg;
            state_reg    <= state_next;
            mclk_reg     <= mclk_next;
            cnt_reg      <= cnt_next;
            cmd_reg      <= cmd_next;
            sel_reg      <= sel_next;
            mask_reg     <= mask_next;
            cke_reg      <= cke_next;
            addr_reg     <= addr_next;
            req_seen_reg <= req_seen_next;
            ack_tgl_reg  <= ack_tgl_next;
        end
    end

    sequence s_activate;
        $fell(row_strobe_n);
    endsequence

    sequence s_access;
        ##[1:20] !column_strobe_n;
    endsequence

    a_row_strobe_addr: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        !row_strobe_n |-> (mem_addr_out == row_addr) && column_strobe_n)
        else $error("row strobe without row address");

    a_col_strobe_addr: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        !column_strobe_n |-> (mem_addr_out == col_addr) && row_strobe_n)
        else $error("column strobe without column address");

    a_write_strobe_dir: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        !column_strobe_n |-> (mem_write_strobe_n == !hold_write_reg))
        else $error("write strobe disagrees with access direction");

    a_block_select_one: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        $onehot0(~mem_block_select_n) && (row_strobe_n || mem_block_select_n != scm_pkg::SEL_NONE))
        else $error("block select not a single block");

    a_cke_command_bit: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        (mclk_reg && csel_s2_reg) |=> (mem_clock_enable == $past(cbit_s2_reg)))
        else $error("clock enable does not carry command bit");

    a_cke_power_down: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        (mclk_reg && !csel_s2_reg) |=> (mem_clock_enable == !$past(pd_s2_reg)))
        else $error("clock enable does not follow power-down");

    a_byte_mask_cmd: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        !column_strobe_n |-> (byte_mask_out == hold_mask_reg))
        else $error("byte mask wrong during column command");

    a_clock_toggle: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        ($past(link_rst_n) |-> (mem_clock_out != $past(mem_clock_out)))
        and ($changed(cmd_reg) |-> !mem_clock_out))
        else $error("memory clock stalled or command moved on its rise");

    a_pin18_col_map: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        (!column_strobe_n && is_32 && hold_cols_reg != scm_pkg::COLS_8) |-> (mem_addr_out[18] == 1'b0))
        else $error("pin 18 driven on wide 32-bit column");

    a_act_then_access: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        s_activate |-> s_access)
        else $error("activation not followed by column command");

    a_ready_after_done: assert property (
        @(posedge clk) disable iff (!rst_n)
        req_done |-> req_ready)
        else $error("done without ready");
endmodule

// ---- verification/scm_mem_model.sv ----
// Purpose: Memory device model, captures activate and column commands
// Assumes: Memory samples every pin on the rising memory clock
// Notes:   Reports one event per column command, row kept from activate
`timescale 1ns/10ps
module scm_mem_model (
    input  wire logic        mem_clock_out,
    input  wire logic        rst_n,
    input  wire logic        row_strobe_n,
    input  wire logic        column_strobe_n,
    input  wire logic        mem_write_strobe_n,
    input  wire logic [1:0]  mem_block_select_n,
    input  wire logic [1:0]  byte_mask_out,
    input  wire logic [16:0] mem_addr_out,
    output logic             ev_valid,
    output logic [16:0]      ev_row,
    output logic [16:0]      ev_col,
    output logic             ev_we_n,
    output logic [1:0]       ev_mask,
    output logic [1:0]       ev_sel,
    output logic [1:0]       ev_selc,
    output logic [7:0]       ev_gap
);
    logic [16:0] act_row;
    logic [1:0]  act_sel;
    logic [7:0]  gap;
    // Pins sampled on the forwarded clock only
    always_ff @(posedge mem_clock_out or negedge rst_n) begin
        if (!rst_n) begin
            ev_valid <= 1'b0;
            gap      <= 8'h00;
        end else begin
            ev_valid <= 1'b0;
            gap      <= gap + 8'h01;
            // Row bits wired straight, the same mapping for every port width
            if (!row_strobe_n && column_strobe_n) begin
                act_row <= mem_addr_out;
                act_sel <= mem_block_select_n;
                gap     <= 8'h00;
            end
            if (row_strobe_n && !column_strobe_n) begin
                ev_valid <= 1'b1;
                ev_row   <= act_row;
                ev_col   <= mem_addr_out;
                ev_we_n  <= mem_write_strobe_n;
                ev_mask  <= byte_mask_out;
                ev_sel   <= act_sel;
                ev_selc  <= mem_block_select_n;
                ev_gap   <= gap + 8'h01;
            end
        end
    end
endmodule

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the command and address multiplexer
// Assumes: Expected results noted at take, compared on column commands
// Notes:   Link clock free running, unrelated phase
`timescale 1ns/10ps
module tb_top;
    localparam int TB_GAP = 2;
    typedef struct {
        logic [16:0] row;
        logic [16:0] col;
        logic        we_n;
        logic [1:0]  mask;
        logic [1:0]  sel;
    } scm_exp_s;
    logic clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, req_block = 1'b0;
    logic [31:0] req_addr = 32'h0;
    logic [1:0] req_byte_mask = 2'h0, port_size = 2'h0;
    logic [3:0] col_lines = 4'h8;
    logic power_down = 1'b0, cke_command_select = 1'b0, cke_command_bit = 1'b0;
    logic req_ready, req_done, mem_clock_out, row_strobe_n, column_strobe_n;
    logic mem_write_strobe_n, mem_clock_enable, ev_valid, ev_we_n;
    logic [1:0] mem_block_select_n, byte_mask_out, ev_mask, ev_sel, ev_selc;
    logic [16:0] mem_addr_out, ev_row, ev_col;
    logic [7:0] ev_gap;
    logic [31:0] seed = 32'h284b3ab2;
    int fail_count = 0, compares = 0, sent = 0, dones = 0, cycles = 0, d0;
    scm_exp_s exp_q[$];
    scm_exp_s me;
    always #25 clk = ~clk;
    always #7.5 link_clk = ~link_clk;
    scm_sdram_cmd_mux #(.ACT_GAP(TB_GAP)) scm_sdram_cmd_mux_i (.clk, .rst_n, .link_clk, .req_valid,
        .req_write, .req_addr, .req_block, .req_byte_mask, .port_size, .col_lines, .power_down,
        .cke_command_select, .cke_command_bit, .req_ready, .req_done, .mem_clock_out, .row_strobe_n,
        .column_strobe_n, .mem_write_strobe_n, .mem_block_select_n, .mem_clock_enable, .byte_mask_out,
        .mem_addr_out(mem_addr_out));
    scm_mem_model scm_mem_model_i (.mem_clock_out, .rst_n, .row_strobe_n, .column_strobe_n,
        .mem_write_strobe_n, .mem_block_select_n, .byte_mask_out, .mem_addr_out, .ev_valid, .ev_row,
        .ev_col, .ev_we_n, .ev_mask, .ev_sel, .ev_selc, .ev_gap);
    function automatic logic [31:0] xs(logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [16:0] col_map(logic [31:0] a, logic [1:0] p, logic [3:0] c);
        logic [16:0] m;
        m = '0;
        for (int i = 9; i <= 15; i++) m[i-9] = a[17-i];
        if (p == scm_pkg::PORT_8 || p == scm_pkg::PORT_16) m[7] = a[1];
        if (p == scm_pkg::PORT_8) m[8] = a[0];
        else if (p != scm_pkg::PORT_16) m[8] = a[16];
        if (p == scm_pkg::PORT_16 || (p != scm_pkg::PORT_8 && c == scm_pkg::COLS_8)) m[9] = a[17];
        if (!(p == scm_pkg::PORT_16 && c < scm_pkg::COLS_9)) m[10] = a[18];
        for (int i = 20; i <= 25; i++) m[i-9] = a[i-1];
        return m;
    endfunction
    task automatic cmp_pin(input string nm, input logic [16:0] e, input logic [16:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_flag(input string nm, input logic e, input logic g);
        cmp_pin(nm, {16'h0, e}, {16'h0, g});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic send(input logic [1:0] p, input logic [3:0] c);
        scm_exp_s e;
        int n;
        seed = xs(seed);
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= seed[0];
        req_addr <= seed;
        req_block <= seed[1];
        req_byte_mask <= seed[3:2];
        port_size <= p;
        col_lines <= c;
        e = '{seed[25:9], col_map(seed, p, c), ~seed[0], seed[3:2], seed[1] ? 2'h1 : 2'h2};
        n = 0;
        // Ready looked at mid-cycle, so the next rising edge is the take
        do begin
            @(negedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 400);
        if (n >= 400) fail_count++;
        @(posedge clk);
        exp_q.push_back(e);
        sent++;
    endtask
    task automatic drain(input string nm);
        int n;
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        while (exp_q.size() != 0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) fail_count++;
        repeat (6) @(posedge clk);
        cmp_pin("pending", 17'h0, 17'(exp_q.size()));
        cmp_pin("done count", 17'(sent), 17'(dones));
        $display("test %s done", nm);
    endtask
    // Done pulse looked at mid-cycle, away from the edge that launches it
    always @(negedge clk) begin
        if (req_done === 1'b1) dones++;
        cycles++;
        if (cycles >= 8000) begin
            fail_count++;
            report_and_stop();
        end
    end
    always @(negedge mem_clock_out) begin
        if (ev_valid === 1'b1 && exp_q.size() == 0) begin
            fail_count++;
            $display("[ERR] column command expected none seen one");
        end else if (ev_valid === 1'b1) begin
            me = exp_q.pop_front();
            cmp_pin("row addr", me.row, ev_row);
            cmp_pin("col addr", me.col, ev_col);
            cmp_flag("write strobe", me.we_n, ev_we_n);
            cmp_pin("mask", {15'h0, me.mask}, {15'h0, ev_mask});
            cmp_pin("act select", {15'h0, me.sel}, {15'h0, ev_sel});
            cmp_pin("col select", {15'h0, me.sel}, {15'h0, ev_selc});
            cmp_pin("act gap", 17'(TB_GAP), {9'h0, ev_gap});
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        cmp_flag("reset cke", scm_pkg::CKE_RESET, mem_clock_enable);
        cmp_pin("reset mask", {15'h0, scm_pkg::MASK_RESET}, {15'h0, byte_mask_out});
        cmp_pin("reset select", {15'h0, scm_pkg::SEL_NONE}, {15'h0, mem_block_select_n});
        cmp_flag("reset row strobe", 1'b1, row_strobe_n);
        rst_n <= 1'b1;
        for (int p = 0; p < 4; p++) for (int c = 8; c <= 13; c++) send(2'(p), 4'(c));
        drain("mapping table");
        cmp_flag("cke running", 1'b1, mem_clock_enable);
        power_down <= 1'b1;
        repeat (20) @(posedge clk);
        cmp_flag("cke power down", 1'b0, mem_clock_enable);
        d0 = dones;
        send(scm_pkg::PORT_16, scm_pkg::COLS_9);
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (40) @(posedge clk);
        cmp_pin("blocked", 17'(d0), 17'(dones));
        power_down <= 1'b0;
        drain("power down");
        power_down <= 1'b1;
        cke_command_select <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            cke_command_bit <= 1'(b);
            repeat (20) @(posedge clk);
            cmp_flag("cke command bit", 1'(b), mem_clock_enable);
        end
        send(scm_pkg::PORT_8, 4'ha);
        drain("command select");
        power_down <= 1'b0;
        cke_command_select <= 1'b0;
        repeat (20) begin
            seed = xs(seed);
            send(seed[5:4], 4'h8 + 4'(seed[10:8] % 6));
        end
        drain("random");
        report_and_stop();
    end
endmodule
